// file: rtl/ccr_pkg.sv
package ccr_pkg;

  // Register offsets
  localparam logic [7:0] CCR_OFS_CONVERTER_CONTROL = 8'hD0;
  localparam logic [7:0] CCR_OFS_OUTPUT_CURRENT_LIMIT = 8'hD1;
  localparam logic [7:0] CCR_OFS_LINE_DROP_CONTROL = 8'hD2;
  localparam logic [7:0] CCR_OFS_SWITCH_LIMIT_CONTROL = 8'hD3;
  localparam logic [7:0] CCR_OFS_BUS_ADDRESS_CONTROL = 8'hD4;
  localparam logic [7:0] CCR_OFS_ALERT_MASK = 8'hD8;
  localparam logic [7:0] CCR_OFS_CONFIG_CODE = 8'hD9;
  localparam logic [7:0] CCR_OFS_CONFIG_REVISION = 8'hDA;

  // Field positions
  localparam int CCR_BIT_DITHER_ON = 7;
  localparam int CCR_POS_RATE_SELECT = 5;
  localparam int CCR_POS_SWITCH_A_RON = 3;
  localparam int CCR_BIT_OVERVOLTAGE_GUARD = 2;
  localparam int CCR_BIT_DISCHARGE_ON = 1;
  localparam int CCR_BIT_LIGHT_LOAD = 0;
  localparam int CCR_BIT_LINE_DROP_OFF = 7;
  localparam int CCR_ADDR_LOW_W = 5;

  // Reset values
  localparam logic [7:0] CCR_RST_CONVERTER_CONTROL = 8'hAF;
  localparam logic [7:0] CCR_RST_OUTPUT_CURRENT_LIMIT = 8'h6C;
  localparam logic [7:0] CCR_RST_LINE_DROP_CONTROL = 8'h00;
  localparam logic [7:0] CCR_RST_SWITCH_LIMIT_CONTROL = 8'h80;
  localparam logic [7:0] CCR_RST_BUS_ADDRESS_CONTROL = 8'h07;
  localparam logic [7:0] CCR_RST_ALERT_MASK = 8'h00;
  // Identity bytes: arbitrary neutral values
  localparam logic [7:0] CCR_RST_CONFIG_CODE = 8'h00;
  localparam logic [7:0] CCR_RST_CONFIG_REVISION = 8'h00;

  // Target address: top two bits fixed, low five programmable
  localparam logic [1:0] CCR_ADDR_HIGH = 2'h3;
  localparam logic [6:0] CCR_ADDR_DEFAULT = 7'h67;

  // Current limit: 50 mA per code, clamped at code 108 (5.4 A)
  localparam logic [6:0] CCR_ILIM_MAX_CODE = 7'h6C;
  localparam int CCR_ILIM_STEP_MA = 50;

  // Switching rates in kHz and on-resistance in milliohm
  localparam logic [9:0] CCR_RATE_0_KHZ = 10'h118;
  localparam logic [9:0] CCR_RATE_1_KHZ = 10'h1A4;
  localparam logic [9:0] CCR_RATE_2_KHZ = 10'h244;
  localparam logic [4:0] CCR_RON_STEP_MOHM = 5'h05;

  // Timing
  localparam int CCR_CLK_KHZ = 100000;
  localparam int CCR_DISCHARGE_MS = 200;
  localparam int CCR_DISCHARGE_CYCLES = CCR_DISCHARGE_MS * CCR_CLK_KHZ;
  localparam int CCR_TMR_W = 25;

  typedef enum logic [3:0] {
    CCR_IDLE = 4'h0,
    CCR_ADDR = 4'h1,
    CCR_ADDR_ACK = 4'h3,
    CCR_PTR = 4'h2,
    CCR_PTR_ACK = 4'h6,
    CCR_WDATA = 4'h7,
    CCR_WACK = 4'h5,
    CCR_RDATA = 4'h4,
    CCR_RACK = 4'hC
  } ccr_phase_e;

  typedef struct packed {
    logic [7:0] converter_control;
    logic [7:0] output_current_limit;
    logic [7:0] line_drop_control;
    logic [7:0] switch_limit_control;
    logic [7:0] bus_address_control;
    logic [7:0] alert_mask;
    logic [7:0] config_code;
    logic [7:0] config_revision;
  } ccr_regs_s;

  typedef struct packed {
    logic dither_on;
    logic [1:0] switching_rate_select;
    logic [9:0] switching_rate_khz;
    logic rate_code_reserved;
    logic [1:0] switch_a_on_resistance;
    logic [4:0] switch_a_ron_mohm;
    logic overvoltage_guard_on;
    logic discharge_enable;
    logic light_load_operation_select;
    logic [6:0] current_limit_value;
    logic [12:0] overcurrent_threshold_ma;
    logic line_drop_comp_off;
    logic [1:0] line_drop_setting;
    logic [7:0] switch_limit;
    logic [7:0] alert_mask;
    logic [6:0] target_address;
  } ccr_cfg_s;

  typedef struct packed {
    logic scl_m;
    logic scl_s;
    logic scl_d;
    logic sda_m;
    logic sda_s;
    logic sda_d;
    logic off_m;
    logic off_s;
    logic off_d;
    logic empty_m;
    logic empty_s;
    ccr_phase_e phase;
    logic [3:0] bit_cnt;
    logic [7:0] shift;
    logic [7:0] ptr;
    logic rd_dir;
    logic host_nack;
    logic sda_low;
    ccr_regs_s regs;
    logic dis_on;
    logic [CCR_TMR_W-1:0] dis_tmr;
  } ccr_state_s;

endpackage

// file: rtl/ccr_regs.sv
// Summary of operation
// - Answer as bus target at seven-bit address 67h unless the address is changed.
// - Converter control bit 7 set enables spread-spectrum dither; default on.
// - Rate field 00/01/10 gives 280/420/580 kHz; 11 reserved; default 01.
// - Switch-A resistance code 00..11 means 5..20 milliohm, default 01.
// - Converter control bit 2 set enables output overvoltage guard; default on.
// - Bit 1 set enables output discharge during any off period; default on.
// - Output discharge ends when the output is empty, the off period ends, bit 1 clears or a 200 ms timer expires.
// - Bit 0 clear selects automatic light-load mode, set forces PWM; default set.
// - Current limit is a seven-bit code in bits 6..0, 50 mA per code.
// - Codes above 5.4 A are clamped to 5.4 A.
// - Current limit register resets to code 108 with compensation-off bit clear.
// - Bit 7 clear leaves line-drop compensation to 0xD2; set disables it.
`timescale 1ns/1ps
`default_nettype none
module ccr_regs
  import ccr_pkg::*;
#(
  parameter int DISCHARGE_CYCLES = CCR_DISCHARGE_CYCLES
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_n,
  input wire logic otp_load,
  input wire ccr_regs_s otp_image,
  input wire logic off_period,
  input wire logic vout_empty,
  output ccr_cfg_s cfg,
  output logic discharge_active
);

  localparam logic [CCR_TMR_W-1:0] TMR_LAST = CCR_TMR_W'(DISCHARGE_CYCLES - 1);

  ccr_state_s st_ff;
  ccr_state_s nxt_st;

  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;
  logic [6:0] own_addr;
  logic [7:0] rd_byte;

  function automatic logic [7:0] reg_read(input ccr_regs_s r, input logic [7:0] ofs);
    logic [7:0] v;
    v = 8'h00;
    case (ofs)
      CCR_OFS_CONVERTER_CONTROL: v = r.converter_control;
      CCR_OFS_OUTPUT_CURRENT_LIMIT: v = r.output_current_limit;
      CCR_OFS_LINE_DROP_CONTROL: v = r.line_drop_control;
      CCR_OFS_SWITCH_LIMIT_CONTROL: v = r.switch_limit_control;
      CCR_OFS_BUS_ADDRESS_CONTROL: v = r.bus_address_control;
      CCR_OFS_ALERT_MASK: v = r.alert_mask;
      CCR_OFS_CONFIG_CODE: v = r.config_code;
      CCR_OFS_CONFIG_REVISION: v = r.config_revision;
      default: v = 8'h00;
    endcase
    return v;
  endfunction

  function automatic ccr_regs_s reg_write(input ccr_regs_s r, input logic [7:0] ofs,
                                          input logic [7:0] d);
    ccr_regs_s n;
    n = r;
    case (ofs)
      CCR_OFS_CONVERTER_CONTROL: n.converter_control = d;
      CCR_OFS_OUTPUT_CURRENT_LIMIT: n.output_current_limit = d;
      CCR_OFS_LINE_DROP_CONTROL: n.line_drop_control = d;
      CCR_OFS_SWITCH_LIMIT_CONTROL: n.switch_limit_control = d;
      CCR_OFS_BUS_ADDRESS_CONTROL: n.bus_address_control = d;
      CCR_OFS_ALERT_MASK: n.alert_mask = d;
      CCR_OFS_CONFIG_CODE: n.config_code = d;
      CCR_OFS_CONFIG_REVISION: n.config_revision = d;
      default: n = r;
    endcase
    return n;
  endfunction

  // Edges and bus conditions only look at the second and third stages
  assign scl_rise = st_ff.scl_s & ~st_ff.scl_d;
  assign scl_fall = ~st_ff.scl_s & st_ff.scl_d;
  assign bus_start = st_ff.scl_s & st_ff.scl_d & st_ff.sda_d & ~st_ff.sda_s;
  assign bus_stop = st_ff.scl_s & st_ff.scl_d & ~st_ff.sda_d & st_ff.sda_s;
  assign own_addr = {CCR_ADDR_HIGH, st_ff.regs.bus_address_control[CCR_ADDR_LOW_W-1:0]};
  assign rd_byte = reg_read(st_ff.regs, st_ff.ptr);

  always_comb begin
    nxt_st = st_ff;
    nxt_st.scl_m = scl_i;
    nxt_st.scl_s = st_ff.scl_m;
    nxt_st.scl_d = st_ff.scl_s;
    nxt_st.sda_m = sda_i;
    nxt_st.sda_s = st_ff.sda_m;
    nxt_st.sda_d = st_ff.sda_s;
    nxt_st.off_m = off_period;
    nxt_st.off_s = st_ff.off_m;
    nxt_st.off_d = st_ff.off_s;
    nxt_st.empty_m = vout_empty;
    nxt_st.empty_s = st_ff.empty_m;

    // Image load first so a host write in the same cycle takes precedence
    if (otp_load) begin
      nxt_st.regs = otp_image;
    end

    if (bus_start) begin
      nxt_st.phase = CCR_ADDR;
      nxt_st.bit_cnt = 4'h0;
      nxt_st.sda_low = 1'b0;
    end else if (bus_stop) begin
      nxt_st.phase = CCR_IDLE;
      nxt_st.sda_low = 1'b0;
    end else begin
      case (st_ff.phase)
        CCR_IDLE: begin
          nxt_st.sda_low = 1'b0;
        end
        CCR_ADDR: begin
          if (scl_rise) begin
            nxt_st.shift = {st_ff.shift[6:0], st_ff.sda_s};
            nxt_st.bit_cnt = st_ff.bit_cnt + 4'h1;
          end else if (scl_fall && st_ff.bit_cnt == 4'h8) begin
            if (st_ff.shift[7:1] == own_addr) begin
              nxt_st.rd_dir = st_ff.shift[0];
              nxt_st.sda_low = 1'b1;
              nxt_st.phase = CCR_ADDR_ACK;
            end else begin
              nxt_st.phase = CCR_IDLE;
            end
          end
        end
        CCR_ADDR_ACK: begin
          if (scl_fall) begin
            nxt_st.bit_cnt = 4'h0;
            if (st_ff.rd_dir) begin
              nxt_st.shift = rd_byte;
              nxt_st.sda_low = ~rd_byte[7];
              nxt_st.phase = CCR_RDATA;
            end else begin
              nxt_st.sda_low = 1'b0;
              nxt_st.phase = CCR_PTR;
            end
          end
        end
        CCR_PTR: begin
          if (scl_rise) begin
            nxt_st.shift = {st_ff.shift[6:0], st_ff.sda_s};
            nxt_st.bit_cnt = st_ff.bit_cnt + 4'h1;
          end else if (scl_fall && st_ff.bit_cnt == 4'h8) begin
            nxt_st.ptr = st_ff.shift;
            nxt_st.sda_low = 1'b1;
            nxt_st.phase = CCR_PTR_ACK;
          end
        end
        CCR_PTR_ACK: begin
          if (scl_fall) begin
            nxt_st.sda_low = 1'b0;
            nxt_st.bit_cnt = 4'h0;
            nxt_st.phase = CCR_WDATA;
          end
        end
        CCR_WDATA: begin
          if (scl_rise) begin
            nxt_st.shift = {st_ff.shift[6:0], st_ff.sda_s};
            nxt_st.bit_cnt = st_ff.bit_cnt + 4'h1;
          end else if (scl_fall && st_ff.bit_cnt == 4'h8) begin
            nxt_st.regs = reg_write(nxt_st.regs, st_ff.ptr, st_ff.shift);
            nxt_st.ptr = st_ff.ptr + 8'h01;
            nxt_st.sda_low = 1'b1;
            nxt_st.phase = CCR_WACK;
          end
        end
        CCR_WACK: begin
          if (scl_fall) begin
            nxt_st.sda_low = 1'b0;
            nxt_st.bit_cnt = 4'h0;
            nxt_st.phase = CCR_WDATA;
          end
        end
        CCR_RDATA: begin
          if (scl_rise) begin
            nxt_st.bit_cnt = st_ff.bit_cnt + 4'h1;
          end else if (scl_fall) begin
            if (st_ff.bit_cnt == 4'h8) begin
              nxt_st.sda_low = 1'b0;
              nxt_st.ptr = st_ff.ptr + 8'h01;
              nxt_st.phase = CCR_RACK;
            end else begin
              nxt_st.shift = {st_ff.shift[6:0], 1'b0};
              nxt_st.sda_low = ~st_ff.shift[6];
            end
          end
        end
        CCR_RACK: begin
          if (scl_rise) begin
            nxt_st.host_nack = st_ff.sda_s;
          end else if (scl_fall) begin
            nxt_st.bit_cnt = 4'h0;
            if (st_ff.host_nack) begin
              // Host declined more data: release the line until stop or start
              nxt_st.phase = CCR_IDLE;
            end else begin
              nxt_st.shift = rd_byte;
              nxt_st.sda_low = ~rd_byte[7];
              nxt_st.phase = CCR_RDATA;
            end
          end
        end
        default: begin
          nxt_st.phase = CCR_IDLE;
          nxt_st.sda_low = 1'b0;
        end
      endcase
    end

    // Discharge runs once per off period; the timer cuts it short of a full discharge
    if (st_ff.dis_on) begin
      nxt_st.dis_tmr = st_ff.dis_tmr + CCR_TMR_W'(1);
      if (st_ff.dis_tmr == TMR_LAST || st_ff.empty_s || !st_ff.off_s ||
          !st_ff.regs.converter_control[CCR_BIT_DISCHARGE_ON]) begin
        nxt_st.dis_on = 1'b0;
      end
    end else if (st_ff.off_s && !st_ff.off_d &&
                 st_ff.regs.converter_control[CCR_BIT_DISCHARGE_ON]) begin
      nxt_st.dis_on = 1'b1;
      nxt_st.dis_tmr = '0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      st_ff.scl_m <= 1'b1;
      st_ff.scl_s <= 1'b1;
      st_ff.scl_d <= 1'b1;
      st_ff.sda_m <= 1'b1;
      st_ff.sda_s <= 1'b1;
      st_ff.sda_d <= 1'b1;
      st_ff.off_m <= 1'b0;
      st_ff.off_s <= 1'b0;
      st_ff.off_d <= 1'b0;
      st_ff.empty_m <= 1'b0;
      st_ff.empty_s <= 1'b0;
      st_ff.phase <= CCR_IDLE;
      st_ff.bit_cnt <= 4'h0;
      st_ff.shift <= 8'h00;
      st_ff.ptr <= 8'h00;
      st_ff.rd_dir <= 1'b0;
      st_ff.host_nack <= 1'b0;
      st_ff.sda_low <= 1'b0;
      st_ff.regs.converter_control <= CCR_RST_CONVERTER_CONTROL;
      st_ff.regs.output_current_limit <= CCR_RST_OUTPUT_CURRENT_LIMIT;
      st_ff.regs.line_drop_control <= CCR_RST_LINE_DROP_CONTROL;
      st_ff.regs.switch_limit_control <= CCR_RST_SWITCH_LIMIT_CONTROL;
      st_ff.regs.bus_address_control <= CCR_RST_BUS_ADDRESS_CONTROL;
      st_ff.regs.alert_mask <= CCR_RST_ALERT_MASK;
      st_ff.regs.config_code <= CCR_RST_CONFIG_CODE;
      st_ff.regs.config_revision <= CCR_RST_CONFIG_REVISION;
      st_ff.dis_on <= 1'b0;
      st_ff.dis_tmr <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Open-drain data line: only ever pulled low
  assign sda_o = 1'b0;
  assign sda_oe_n = ~st_ff.sda_low;
  assign discharge_active = st_ff.dis_on;

  logic [7:0] cc;
  logic [6:0] ilim_code;
  logic [6:0] ilim_eff;

  assign cc = st_ff.regs.converter_control;
  assign ilim_code = st_ff.regs.output_current_limit[6:0];

  always_comb begin
    ilim_eff = ilim_code;
    if (ilim_code > CCR_ILIM_MAX_CODE) begin
      ilim_eff = CCR_ILIM_MAX_CODE;
    end
    cfg.dither_on = cc[CCR_BIT_DITHER_ON];
    cfg.switching_rate_select = cc[CCR_POS_RATE_SELECT +: 2];
    cfg.rate_code_reserved = 1'b0;
    case (cc[CCR_POS_RATE_SELECT +: 2])
      2'h0: cfg.switching_rate_khz = CCR_RATE_0_KHZ;
      2'h1: cfg.switching_rate_khz = CCR_RATE_1_KHZ;
      2'h2: cfg.switching_rate_khz = CCR_RATE_2_KHZ;
      default: begin
        // Reserved code: hold the default rate and flag it
        cfg.switching_rate_khz = CCR_RATE_1_KHZ;
        cfg.rate_code_reserved = 1'b1;
      end
    endcase
    cfg.switch_a_on_resistance = cc[CCR_POS_SWITCH_A_RON +: 2];
    cfg.switch_a_ron_mohm = 5'(({3'h0, cc[CCR_POS_SWITCH_A_RON +: 2]} + 5'h01) * CCR_RON_STEP_MOHM);
    cfg.overvoltage_guard_on = cc[CCR_BIT_OVERVOLTAGE_GUARD];
    cfg.discharge_enable = cc[CCR_BIT_DISCHARGE_ON];
    cfg.light_load_operation_select = cc[CCR_BIT_LIGHT_LOAD];
    cfg.current_limit_value = ilim_eff;
    cfg.overcurrent_threshold_ma = 13'(ilim_eff * CCR_ILIM_STEP_MA);
    cfg.line_drop_comp_off = st_ff.regs.output_current_limit[CCR_BIT_LINE_DROP_OFF];
    cfg.line_drop_setting = cfg.line_drop_comp_off ? 2'h0 : st_ff.regs.line_drop_control[1:0];
    cfg.switch_limit = st_ff.regs.switch_limit_control;
    cfg.alert_mask = st_ff.regs.alert_mask;
    cfg.target_address = own_addr;
  end

endmodule
`default_nettype wire

// file: tb/ccr_regs_checker.sv
`timescale 1ns/1ps
`default_nettype none
module ccr_regs_checker
  import ccr_pkg::*;
#(
  parameter int DISCHARGE_CYCLES = CCR_DISCHARGE_CYCLES
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic sda_o,
  input wire logic sda_oe_n,
  input wire logic otp_load,
  input wire ccr_regs_s otp_image,
  input wire logic off_period,
  input wire logic vout_empty,
  input wire ccr_cfg_s cfg,
  input wire logic discharge_active
);
  int act_cnt;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  // Counts the length of each discharge instead of a long repetition
  always_ff @(posedge core_clk) begin
    if (rst || !discharge_active) begin
      act_cnt <= 0;
    end else begin
      act_cnt <= act_cnt + 1;
    end
  end
  open_drain_a: assert property (sda_o == 1'b0) else $error("data pin driven high");
  reset_state_a: assert property ($fell(rst) |-> sda_oe_n && !discharge_active && cfg.target_address == 7'h67)
    else $error("state after reset wrong");
  limit_clamp_a: assert property (cfg.current_limit_value <= 7'h6C) else $error("limit not clamped");
  limit_step_a: assert property (cfg.overcurrent_threshold_ma == 13'(cfg.current_limit_value) * 13'h0032)
    else $error("threshold not code times step");
  rate_decode_a: assert property ((cfg.switching_rate_select == 2'h0) |-> cfg.switching_rate_khz == 10'h118
    ) else $error("rate decode wrong");
  // Widen before the sum: a three-bit product would wrap the 10, 15 and 20 milliohm codes
  ron_decode_a: assert property (cfg.switch_a_ron_mohm == (5'(cfg.switch_a_on_resistance) + 5'h01) * 5'h05)
    else $error("resistance decode wrong");
  comp_off_a: assert property (cfg.line_drop_comp_off |-> cfg.line_drop_setting == 2'h0)
    else $error("compensation not disabled");
  dis_enable_a: assert property ($rose(discharge_active) |-> cfg.discharge_enable && $past(off_period, 2))
    else $error("discharge without enable");
  dis_timer_a: assert property (act_cnt <= DISCHARGE_CYCLES + 2) else $error("discharge outlasts timer");
  dis_end_a: assert property (!off_period [*8] |-> !discharge_active) else $error("discharge outside off");
  ack_edge_a: assert property ($changed(sda_oe_n) |-> !scl_i) else $error("data moved while clock high");
  cover property ($rose(discharge_active));
  cover property ($fell(sda_oe_n));
  cover property (otp_load);
endmodule
`default_nettype wire

// file: tb/ccr_host.sv
`timescale 1ns/1ps
`default_nettype none
module ccr_host (
  input wire logic core_clk,
  input wire logic sda_oe_n,
  output logic scl,
  output logic sda
);
  logic pull_low;
  // Pull-up: a released line reads 1, never the last driven bit
  assign sda = !(pull_low || !sda_oe_n);
  initial begin
    scl = 1'b1;
    pull_low = 1'b0;
  end
  task automatic half();
    repeat (8) @(posedge core_clk);
    #1;
  endtask
  // Data moves only in mid-low so it never looks like a start or stop
  task automatic bit_x(input logic b, output logic r);
    pull_low = !b;
    half();
    scl = 1'b1;
    half();
    r = sda;
    scl = 1'b0;
    half();
  endtask
  task automatic xfer(input logic [7:0] d, input logic a, output logic [7:0] q, output logic k);
    for (int i = 7; i >= 0; i--) begin
      bit_x(d[i], q[i]);
    end
    bit_x(a, k);
  endtask
  task automatic start();
    pull_low = 1'b0;
    half();
    scl = 1'b1;
    half();
    pull_low = 1'b1;
    half();
    scl = 1'b0;
    half();
  endtask
  task automatic stop();
    pull_low = 1'b1;
    half();
    scl = 1'b1;
    half();
    pull_low = 1'b0;
    half();
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] p, input logic [7:0] d, output logic ok);
    logic [7:0] q;
    logic k0, k1, k2;
    start();
    xfer({a, 1'b0}, 1'b1, q, k0);
    xfer(p, 1'b1, q, k1);
    xfer(d, 1'b1, q, k2);
    stop();
    ok = !(k0 | k1 | k2);
  endtask
  task automatic rd(input logic [6:0] a, input logic [7:0] p, output logic [7:0] d, output logic ok);
    logic [7:0] q;
    logic k0, k1, k2, k3;
    start();
    xfer({a, 1'b0}, 1'b1, q, k0);
    xfer(p, 1'b1, q, k1);
    start();
    xfer({a, 1'b1}, 1'b1, q, k2);
    // Single byte read, so the host refuses it to end the transfer
    xfer(8'hFF, 1'b1, d, k3);
    stop();
    ok = !(k0 | k1 | k2);
  endtask
endmodule
`default_nettype wire

// file: tb/ccr_regs_tb.sv
`timescale 1ns/1ps
`default_nettype none
module ccr_regs_tb;
  import ccr_pkg::*;
  localparam int DC = 200;
  localparam logic [7:0] OFS [8] = '{8'hD0, 8'hD1, 8'hD2, 8'hD3, 8'hD4, 8'hD8, 8'hD9, 8'hDA};
  localparam logic [7:0] RSTV [8] = '{8'hAF, 8'h6C, 8'h00, 8'h80, 8'h07, 8'h00, 8'h00, 8'h00};
  localparam logic [7:0] CORNER [4] = '{8'hFF, 8'h6D, 8'h6C, 8'h00};
  logic core_clk, rst, otp_load, off_period, vout_empty, scl, sda, sda_o, sda_oe_n, discharge_active, ok;
  ccr_regs_s otp_image;
  ccr_cfg_s cfg;
  logic [7:0] d, v;
  logic [4:0] na;
  int num_errors, cmp_count, seed, cyc, n;
  ccr_host i_host (.core_clk(core_clk), .sda_oe_n(sda_oe_n), .scl(scl), .sda(sda));
  ccr_regs #(.DISCHARGE_CYCLES(DC)) i_dut (.core_clk(core_clk), .rst(rst), .scl_i(scl), .sda_i(sda),
    .sda_o(sda_o), .sda_oe_n(sda_oe_n), .otp_load(otp_load), .otp_image(otp_image), .off_period(off_period),
    .vout_empty(vout_empty), .cfg(cfg), .discharge_active(discharge_active));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic conclude();
    $display("comparisons %0d, mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge core_clk);
    #1;
  endtask
  function automatic logic [6:0] exp_lim(input logic [6:0] c);
    return (c > 7'h6C) ? 7'h6C : c;
  endfunction
  function automatic logic [9:0] exp_khz(input logic [1:0] c);
    return (c == 2'h0) ? 10'h118 : (c == 2'h2) ? 10'h244 : 10'h1A4;
  endfunction
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  // Ceiling sits well above the expected run of about 40000 cycles
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 70000) begin
      num_errors++;
      conclude();
    end
  end
  initial begin
    seed = 32'hbb71f854;
    rst = 1'b1;
    otp_load = 1'b0;
    otp_image = '0;
    off_period = 1'b0;
    vout_empty = 1'b0;
    tick(12);
    rst = 1'b0;
    tick(6);
    for (int i = 0; i < 8; i++) begin
      i_host.rd(7'h67, OFS[i], v, ok);
      chk(16'(ok), 16'h0001);
      chk(16'(v), 16'(RSTV[i]));
    end
    chk(16'({cfg.dither_on, cfg.overvoltage_guard_on, cfg.discharge_enable, cfg.light_load_operation_select}),
      16'h000F);
    chk(16'(cfg.switching_rate_khz), 16'h01A4);
    chk(16'(cfg.switch_a_ron_mohm), 16'h000A);
    chk(16'({cfg.line_drop_comp_off, cfg.current_limit_value}), 16'h006C);
    chk(16'({cfg.switch_limit, cfg.alert_mask}), 16'h8000);
    chk(16'(cfg.target_address), 16'h0067);
    $display("test reset values done");
    for (int i = 0; i < 8; i++) begin
      d = (i < 4) ? CORNER[i] : 8'($random(seed));
      i_host.wr(7'h67, 8'hD0, d, ok);
      i_host.wr(7'h67, 8'hD1, d, ok);
      i_host.wr(7'h67, 8'hD2, d, ok);
      chk(16'(ok), 16'h0001);
      i_host.rd(7'h67, 8'hD1, v, ok);
      chk(16'(v), 16'(d));
      chk(16'({cfg.dither_on, cfg.overvoltage_guard_on, cfg.discharge_enable, cfg.light_load_operation_select}),
        16'({d[7], d[2], d[1], d[0]}));
      chk(16'(cfg.switching_rate_khz), 16'(exp_khz(d[6:5])));
      chk(16'({cfg.rate_code_reserved, cfg.switching_rate_select}), 16'({d[6:5] == 2'h3, d[6:5]}));
      chk(16'(cfg.switch_a_on_resistance), 16'(d[4:3]));
      chk(16'(cfg.switch_a_ron_mohm), 16'((d[4:3] + 1) * 5));
      chk(16'(cfg.current_limit_value), 16'(exp_lim(d[6:0])));
      chk(16'(cfg.overcurrent_threshold_ma), 16'(exp_lim(d[6:0])) * 16'h0032);
      chk(16'({cfg.line_drop_comp_off, cfg.line_drop_setting}), 16'(d[7] ? 3'h4 : {1'b0, d[1:0]}));
    end
    $display("test field decode done");
    i_host.wr(7'h67, 8'hD5, 8'hA5, ok);
    chk(16'(ok), 16'h0001);
    i_host.rd(7'h67, 8'hD5, v, ok);
    chk(16'(v), 16'h0000);
    $display("test unmapped pointer done");
    na = 5'($random(seed)) | 5'h10;
    i_host.wr(7'h67, 8'hD4, {3'h0, na}, ok);
    i_host.rd(7'h67, 8'hD4, v, ok);
    chk(16'(ok), 16'h0000);
    i_host.rd({2'h3, na}, 8'hD4, v, ok);
    chk(16'({ok, v}), 16'({1'b1, 3'h0, na}));
    chk(16'(cfg.target_address), 16'({2'h3, na}));
    otp_image = {32'($random(seed)), 32'($random(seed))};
    otp_image.bus_address_control = {3'h0, ~na};
    otp_load = 1'b1;
    tick(1);
    otp_load = 1'b0;
    tick(2);
    i_host.rd({2'h3, ~na}, 8'hD0, v, ok);
    chk(16'({ok, v}), 16'({1'b1, otp_image.converter_control}));
    i_host.wr({2'h3, ~na}, 8'hD4, 8'h07, ok);
    i_host.wr(7'h67, 8'hD0, 8'h02, ok);
    chk(16'(ok), 16'h0001);
    $display("test target address done");
    off_period = 1'b1;
    n = 0;
    while (discharge_active !== 1'b1 && n < 10) begin
      tick(1);
      n++;
    end
    chk(16'(discharge_active), 16'h0001);
    n = 0;
    while (discharge_active === 1'b1 && n < 400) begin
      tick(1);
      n++;
    end
    chk(16'(n >= DC - 4 && n <= DC + 4), 16'h0001);
    off_period = 1'b0;
    tick(10);
    off_period = 1'b1;
    tick(30);
    chk(16'(discharge_active), 16'h0001);
    vout_empty = 1'b1;
    tick(8);
    chk(16'(discharge_active), 16'h0000);
    vout_empty = 1'b0;
    off_period = 1'b0;
    tick(10);
    i_host.wr(7'h67, 8'hD0, 8'h00, ok);
    off_period = 1'b1;
    tick(20);
    chk(16'(discharge_active), 16'h0000);
    off_period = 1'b0;
    $display("test discharge done");
    conclude();
  end
endmodule
bind ccr_regs ccr_regs_checker #(.DISCHARGE_CYCLES(DISCHARGE_CYCLES)) i_chk (.core_clk(core_clk), .rst(rst),
  .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o), .sda_oe_n(sda_oe_n), .otp_load(otp_load), .otp_image(otp_image),
  .off_period(off_period), .vout_empty(vout_empty), .cfg(cfg), .discharge_active(discharge_active));
`default_nettype wire
